/* hw/sirq_ctrl.v */
// Interrupt controller of a dual-channel serial adaptor: 20 sources, ranking,
// enables, one active-low request and acknowledge-cycle vector output.
// Assumes all inputs are synchronous to clk_sys; host strobes are active low.
//
// Contract
// - Twenty on-chip sources combine onto one active-low request output.
// - Default rank: serial ch0, serial ch1, DMA ch0-3 error/done, timers 0-3.
// - Pending source requests the host only while its enable bit is set.
// - Fixed vector stores any written value, output unchanged when selected.
// - Modified vector low six bits carry code of top-ranked active source.
// - Modified vector top two bits are writable and reset to zero.
// - Modified vector low six bits read zero; software writes zeros there.
// - Control bit 7 zero: serial outranks DMA; one: DMA outranks serial.
// - Acknowledge type 00 ignores the strobe and keeps the bus released.
// - Acknowledge type 01 drives the vector at the first low strobe.
// - Acknowledge type 10 drives the vector only at the second low strobe.
// - Control bit 4 picks fixed vector (0) or modified vector (1).
// - Control fields reset to zero; control bits 3 to 0 read zero.
// - Serial status read-only, reset zero, ch1 in bits 7-4, ch0 in 3-0.
// - DMA status read-only, reset zero, per channel error then normal end.
// - Timer status bits 7-4 show count match, bits 3-0 read zero.
// - Each enable register mirrors its status layout and resets to zero.
// - Strobe low with no enabled pending request outputs no vector.

`timescale 1ns/1ns
`default_nettype none
`include "sirq_map.vh"

module sirq_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Host register access
  input wire host_cs_n,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire [3:0] host_addr,
  input wire [7:0] host_data_in,
  output wire [7:0] host_data_out,
  output wire host_data_oe,
  // Interrupt request and acknowledge
  output wire host_irq_n,
  input wire host_ack_strobe_n,
  // Source conditions, laid out like the status registers
  input wire [7:0] serial_src,
  input wire [7:0] dma_src,
  input wire [3:0] timer_src
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0] fixed_vector_reg;
  reg [1:0] modvec_top_reg;
  reg [7:0] irq_control_reg;
  reg [7:0] serial_status_reg;
  reg [7:0] dma_status_reg;
  reg [3:0] timer_status_reg;
  reg [7:0] serial_enable_reg;
  reg [7:0] dma_enable_reg;
  reg [3:0] timer_enable_reg;
  reg [5:0] code_reg;
  reg [5:0] code_next;
  reg irq_n_reg;
  reg ack_prev_reg;
  reg second_ack_reg;
  reg vector_drive_reg;
  reg vector_drive_next;
  reg second_ack_next;
  reg read_drive_reg;
  reg read_drive_next;
  reg data_oe_reg;
  reg data_oe_next;
  reg [7:0] data_out_reg;
  reg [7:0] data_out_next;
  reg [7:0] read_data;
  reg found;
  integer i;

  wire write_en;
  wire read_en;
  wire ack_fall;
  wire ack_taken;
  wire [1:0] ack_type;
  wire [19:0] status_all;
  wire [19:0] enable_all;
  genvar g;
  wire [19:0] pending;
  wire [19:0] ranked;
  wire any_pending;
  wire [7:0] selected_vector;
  wire [7:0] modified_vector;

  assign write_en = ~host_cs_n & ~host_wr_n;
  assign read_en = ~host_cs_n & ~host_rd_n;
  assign ack_fall = ack_prev_reg & ~host_ack_strobe_n;
  assign ack_type = irq_control_reg[`SIRQ_CTL_ACK_HI:`SIRQ_CTL_ACK_LO];

  // --------------------------------------------------------------------------
  // Source status
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serial_status_reg <= `SIRQ_RST_BYTE;
      dma_status_reg <= `SIRQ_RST_BYTE;
      timer_status_reg <= `SIRQ_RST_NIBBLE;
    end else begin
      serial_status_reg <= serial_src;
      dma_status_reg <= dma_src;
      timer_status_reg <= timer_src;
    end
  end

  // --------------------------------------------------------------------------
  // Enabled sources
  // --------------------------------------------------------------------------
  // Source index equals default rank, 0 highest
  assign status_all = {timer_status_reg, dma_status_reg, serial_status_reg};
  assign enable_all = {timer_enable_reg, dma_enable_reg, serial_enable_reg};

  generate
    for (g = 0; g < 20; g = g + 1) begin : g_src
      // Pending source joins ranking only with its enable set
      assign pending[g] = status_all[g] & enable_all[g];
    end
  endgenerate

  assign any_pending = |pending;

  // Ranked view: DMA group moved ahead of serial group when selected
  assign ranked = irq_control_reg[`SIRQ_CTL_GROUP_PRIO] ?
                  {pending[19:16], pending[7:0], pending[15:8]} : pending;

  // --------------------------------------------------------------------------
  // Priority encoder
  // --------------------------------------------------------------------------
  always @* begin
    code_next = 6'h00;
    found = 1'b0;
    for (i = 0; i < 20; i = i + 1) begin
      if (ranked[i] && !found) begin
        found = 1'b1;
        code_next = i[5:0];
      end
    end
    if (irq_control_reg[`SIRQ_CTL_GROUP_PRIO] && found && code_next < 6'h10) begin
      code_next = (code_next < 6'h08) ? code_next + 6'h08 : code_next - 6'h08;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_reg <= 6'h00;
      irq_n_reg <= 1'b1;
    end else begin
      code_reg <= code_next;
      irq_n_reg <= ~any_pending;
    end
  end

  assign modified_vector = {modvec_top_reg, code_reg};
  assign selected_vector = irq_control_reg[`SIRQ_CTL_VEC_SEL] ?
                           modified_vector : fixed_vector_reg;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fixed_vector_reg <= `SIRQ_RST_FIXED_VECTOR;
      modvec_top_reg <= `SIRQ_RST_TOP;
      irq_control_reg <= `SIRQ_RST_BYTE;
      serial_enable_reg <= `SIRQ_RST_BYTE;
      dma_enable_reg <= `SIRQ_RST_BYTE;
      timer_enable_reg <= `SIRQ_RST_NIBBLE;
    end else if (write_en) begin
      case (host_addr)
        `SIRQ_OFS_FIXED_VECTOR: begin
          fixed_vector_reg <= host_data_in;
        end
        `SIRQ_OFS_MODIFIED_VECTOR: begin
          modvec_top_reg <= host_data_in[7:6];
        end
        `SIRQ_OFS_IRQ_CONTROL: begin
          irq_control_reg <= host_data_in & `SIRQ_CTL_MASK;
        end
        `SIRQ_OFS_SERIAL_ENABLE: begin
          serial_enable_reg <= host_data_in;
        end
        `SIRQ_OFS_DMA_ENABLE: begin
          dma_enable_reg <= host_data_in;
        end
        `SIRQ_OFS_TIMER_ENABLE: begin
          timer_enable_reg <= host_data_in[7:4];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always @* begin
    case (host_addr)
      `SIRQ_OFS_FIXED_VECTOR: read_data = fixed_vector_reg;
      `SIRQ_OFS_MODIFIED_VECTOR: read_data = {modvec_top_reg, 6'h00};
      `SIRQ_OFS_IRQ_CONTROL: read_data = irq_control_reg & `SIRQ_CTL_MASK;
      `SIRQ_OFS_SERIAL_STATUS: read_data = serial_status_reg;
      `SIRQ_OFS_DMA_STATUS: read_data = dma_status_reg;
      `SIRQ_OFS_TIMER_STATUS: read_data = {timer_status_reg, 4'h0};
      `SIRQ_OFS_SERIAL_ENABLE: read_data = serial_enable_reg;
      `SIRQ_OFS_DMA_ENABLE: read_data = dma_enable_reg;
      `SIRQ_OFS_TIMER_ENABLE: read_data = {timer_enable_reg, 4'h0};
      default: read_data = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Acknowledge cycles and data bus
  // --------------------------------------------------------------------------
  // Strobe fall only counts while a request is shown to the host
  assign ack_taken = ack_fall & ~irq_n_reg;

  // Vector drive and double-acknowledge arming
  always @* begin
    vector_drive_next = vector_drive_reg;
    second_ack_next = second_ack_reg;
    if (host_ack_strobe_n) begin
      vector_drive_next = 1'b0;
    end
    if (ack_taken) begin
      case (ack_type)
        `SIRQ_ACK_SINGLE: begin
          vector_drive_next = 1'b1;
        end
        `SIRQ_ACK_DOUBLE: begin
          if (second_ack_reg) begin
            vector_drive_next = 1'b1;
            second_ack_next = 1'b0;
          end else begin
            second_ack_next = 1'b1;
          end
        end
        default: begin
          second_ack_next = 1'b0;
        end
      endcase
    end
    if (ack_type != `SIRQ_ACK_DOUBLE) begin
      second_ack_next = 1'b0;
    end
  end

  // Read drive yields to a vector being driven
  always @* begin
    read_drive_next = read_en & ~vector_drive_reg;
    data_oe_next = vector_drive_next | read_drive_next;
  end

  // Data bus contents
  always @* begin
    data_out_next = data_out_reg;
    if (vector_drive_reg) begin
      data_out_next = data_out_reg;
    end else if (read_en) begin
      data_out_next = read_data;
    end
    if (ack_taken) begin
      data_out_next = selected_vector;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_prev_reg <= 1'b1;
      second_ack_reg <= 1'b0;
      vector_drive_reg <= 1'b0;
      read_drive_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      data_out_reg <= `SIRQ_RST_BYTE;
    end else begin
      ack_prev_reg <= host_ack_strobe_n;
      data_out_reg <= data_out_next;
      read_drive_reg <= read_drive_next;
      vector_drive_reg <= vector_drive_next;
      second_ack_reg <= second_ack_next;
      data_oe_reg <= data_oe_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign host_data_out = data_out_reg;
  assign host_data_oe = data_oe_reg;
  assign host_irq_n = irq_n_reg;

endmodule // sirq_ctrl

`default_nettype wire

/* hw/sirq_map.vh */
// Register offsets, field positions and reset values of the serial adaptor
// interrupt controller. Included by the controller; holds definitions only.
`ifndef SIRQ_MAP_VH
`define SIRQ_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SIRQ_OFS_FIXED_VECTOR 4'h0
`define SIRQ_OFS_MODIFIED_VECTOR 4'h1
`define SIRQ_OFS_IRQ_CONTROL 4'h2
`define SIRQ_OFS_SERIAL_STATUS 4'h4
`define SIRQ_OFS_DMA_STATUS 4'h5
`define SIRQ_OFS_TIMER_STATUS 4'h6
`define SIRQ_OFS_SERIAL_ENABLE 4'h8
`define SIRQ_OFS_DMA_ENABLE 4'h9
`define SIRQ_OFS_TIMER_ENABLE 4'ha

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define SIRQ_CTL_GROUP_PRIO 7
`define SIRQ_CTL_ACK_HI 6
`define SIRQ_CTL_ACK_LO 5
`define SIRQ_CTL_VEC_SEL 4
`define SIRQ_CTL_MASK 8'hf0
`define SIRQ_MODVEC_TOP_MASK 8'hc0
`define SIRQ_TIMER_MASK 8'hf0

// ----------------------------------------------------------------------------
// Acknowledge types
// ----------------------------------------------------------------------------
`define SIRQ_ACK_NONE 2'h0
`define SIRQ_ACK_SINGLE 2'h1
`define SIRQ_ACK_DOUBLE 2'h2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SIRQ_RST_BYTE 8'h00
`define SIRQ_RST_FIXED_VECTOR 8'h00
`define SIRQ_RST_NIBBLE 4'h0
`define SIRQ_RST_TOP 2'h0

`endif

/* tb/sirq_ctrl_props.sv */
// Port checker for the serial adaptor interrupt controller.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ns
`default_nettype none
module sirq_ctrl_props (
  // Clock, reset and host bus
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  // Interrupt and sources
  input wire logic host_irq_n,
  input wire logic host_ack_strobe_n,
  input wire logic [7:0] serial_src,
  input wire logic [7:0] dma_src,
  input wire logic [3:0] timer_src
);
  // ----------
  // Properties
  // ----------
  wire any_src = |{serial_src, dma_src, timer_src};
  wire rd_now = !host_cs_n && !host_rd_n && host_ack_strobe_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_cause; !host_irq_n |-> $past(any_src, 2); endproperty
  a_cause: assert property (p_cause) else $error("request without source");
  property p_quiet; !any_src [*3] |=> host_irq_n; endproperty
  a_quiet: assert property (p_quiet) else $error("request while idle");
  property p_tmr; rd_now && $past(host_ack_strobe_n) && host_addr == 4'h6 |=> host_data_out[3:0] == 4'h0; endproperty
  a_tmr: assert property (p_tmr) else $error("timer status low bits");
  property p_mv; rd_now && $past(host_ack_strobe_n) && host_addr == 4'h1 |=> host_data_out[5:0] == 6'h00; endproperty
  a_mv: assert property (p_mv) else $error("vector low bits");
  property p_ctl; rd_now && $past(host_ack_strobe_n) && host_addr == 4'h2 |=> host_data_out[3:0] == 4'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control low bits");
  property p_oe; host_data_oe |-> !$past(host_rd_n) || !$past(host_ack_strobe_n) || !$past(host_ack_strobe_n, 2); endproperty
  a_oe: assert property (p_oe) else $error("bus driven unasked");
  property p_nack; $fell(host_ack_strobe_n) && host_irq_n && host_rd_n && !host_data_oe |=> !host_data_oe; endproperty
  a_nack: assert property (p_nack) else $error("vector without request");
  property p_rel; $fell(rst) |-> host_irq_n && !host_data_oe; endproperty
  a_rel: assert property (p_rel) else $error("busy after reset");
endmodule // sirq_ctrl_props
bind sirq_ctrl sirq_ctrl_props u_props (.clk_sys(clk_sys), .rst(rst), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
  .host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
  .host_data_oe(host_data_oe), .host_irq_n(host_irq_n), .host_ack_strobe_n(host_ack_strobe_n),
  .serial_src(serial_src), .dma_src(dma_src), .timer_src(timer_src));
`default_nettype wire

/* tb/sirq_host_model.sv */
// Host processor model issuing interrupt acknowledge cycles.
// Assumes the strobe idles high and the bus is sampled on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module sirq_host_model (
  // Clock and vector bus
  input wire logic clk_sys,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  // Strobe
  output var logic host_ack_strobe_n
);
  // ------------------
  // Acknowledge cycles
  // ------------------
  initial host_ack_strobe_n = 1'b1;
  task automatic ack(input int hold, output logic [8:0] got);
    got = 9'h000;
    @(posedge clk_sys) host_ack_strobe_n <= 1'b0;
    repeat (hold) begin
      @(posedge clk_sys) #1;
      if (host_data_oe === 1'b1) got = {1'b1, host_data_out};
    end
    @(posedge clk_sys) host_ack_strobe_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // sirq_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the serial adaptor interrupt controller.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // -------
  // Signals
  // -------
  logic clk_sys = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic [3:0] addr = 4'h0, tim = 4'h0;
  logic [7:0] din = 8'h00, ser = 8'h00, dma = 8'h00;
  wire [7:0] dout;
  wire oe, irq_n, stb_n;
  int num_errors = 0, check_count = 0;
  always #4 clk_sys = ~clk_sys;
  sirq_ctrl dut (.clk_sys(clk_sys), .rst(rst), .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
    .host_addr(addr), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .host_irq_n(irq_n),
    .host_ack_strobe_n(stb_n), .serial_src(ser), .dma_src(dma), .timer_src(tim));
  sirq_host_model host (.clk_sys(clk_sys), .host_data_out(dout), .host_data_oe(oe), .host_ack_strobe_n(stb_n));
  // -----------------
  // Model and helpers
  // -----------------
  function automatic logic [5:0] code(input logic [19:0] a, input logic sw);
    int i, j;
    code = 6'h00;
    for (i = 19; i >= 0; i--) begin
      j = (sw && i < 16) ? (i + 8) % 16 : i;
      if (a[j]) code = 6'(j);
    end
  endfunction
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) {cs_n, wr_n, addr, din} <= {2'b00, a, d};
    @(posedge clk_sys) {cs_n, wr_n} <= 2'b11;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys) {cs_n, rd_n, addr} <= {2'b00, a};
    @(posedge clk_sys) #1 chk("read", {1'b1, e}, {oe, dout});
    @(posedge clk_sys) {cs_n, rd_n} <= 2'b11;
  endtask
  task tally_and_finish;
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish;
  end
  // -----
  // Tests
  // -----
  initial begin
    logic [19:0] s, en, act;
    logic [7:0] fv, ev;
    logic [8:0] got;
    logic [1:0] top, ty;
    logic sw, sel;
    int k;
    void'($urandom(32'h6248ae5c));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (k = 0; k < 11; k++) rd(4'(k), 8'h00);
    for (k = 0; k < 30; k++) begin
      ty = 2'(k % 3);
      {sw, sel, top, fv} = 12'($urandom);
      s = 20'($urandom & $urandom);
      en = 20'($urandom);
      wr(4'h0, fv);
      wr(4'h1, {top, 6'h00});
      wr(4'h2, {sw, ty, sel, 4'h0});
      wr(4'h8, en[7:0]);
      wr(4'h9, en[15:8]);
      wr(4'ha, {en[19:16], 4'h0});
      @(posedge clk_sys) {tim, dma, ser} <= s;
      repeat (3) @(posedge clk_sys);
      act = s & en;
      chk("irq_n", {8'h00, act == 20'h0}, {8'h00, irq_n});
      rd(4'h4, s[7:0]);
      rd(4'h4, s[7:0]);
      rd(4'h5, s[15:8]);
      rd(4'h6, {s[19:16], 4'h0});
      rd(4'h8, en[7:0]);
      rd(4'h9, en[15:8]);
      rd(4'ha, {en[19:16], 4'h0});
      rd(4'h0, fv);
      rd(4'h1, {top, 6'h00});
      rd(4'h2, {sw, ty, sel, 4'h0});
      ev = sel ? {top, code(act, sw)} : fv;
      if (ty == 2'h2) begin
        host.ack(2, got);
        chk("first_ack", 9'h000, got);
      end
      host.ack(2 + 3 * (k % 2), got);
      chk("vector", (ty != 2'h0 && act != 20'h0) ? {1'b1, ev} : 9'h000, got);
    end
    wr(4'h2, 8'h20);
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'ha, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("irq_n", 9'h001, {8'h00, irq_n});
    host.ack(2, got);
    chk("idle_ack", 9'h000, got);
    @(posedge clk_sys) rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h2, 8'h00);
    rd(4'h9, 8'h00);
    chk("irq_n", 9'h001, {8'h00, irq_n});
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
